// *** hw/in_circuit_test_control.sv ***
// board connectivity test control: pin float and input-to-output test mode
// Functional notes
// R1: float request puts all pins high impedance
// R2: test mode multiplexes inputs onto outputs
// R3: test modes inactive after any reset
// R4: shared pin is input while power low
// R5: shared pin low with power low floats outputs
// R6: strobes toggled together while floated enter test
// R7: tester follows the documented entry sequence
// R8: test mode holds until reset
// R9: clock activity in test mode forces reset
// R10: tester runs double-rate clock with power_ok early
// R11: tester keeps clocks still during test access
// R12: fixed one-to-one input to output pairing
`timescale 1ns/1ns
`include "ict_defs.svh"
module in_circuit_test_control (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // power and shared pin
  input wire logic i_power_ok_input,
  input wire logic i_speaker_float_shared_pin,
  input wire logic i_speaker_out,
  // io strobes, active low, sampled as inputs
  input wire logic i_io_read_n,
  input wire logic i_io_write_n,
  // clocks watched as levels
  input wire logic i_cpu_double_rate_clock,
  input wire logic i_bus_oscillator_input,
  // test pin inputs and normal function outputs
  input wire logic [`ICT_PAIRS-1:0] i_test_in,
  input wire logic [`ICT_PAIRS-1:0] i_func_out,
  input wire logic [`ICT_PAIRS-1:0] i_func_oe,
  // pad drive
  output logic [`ICT_PAIRS-1:0] o_pad_out,
  output logic [`ICT_PAIRS-1:0] o_pad_oe,
  output logic o_speaker_out,
  output logic o_speaker_oe,
  // status
  output logic o_test_mode,
  output logic o_floated,
  output logic o_test_reset
);
  ict_pkg::ict_state_t state_reg;
  ict_pkg::ict_state_t state_next;
  logic [`ICT_PAIRS-1:0] pad_out_reg;
  logic [`ICT_PAIRS-1:0] pad_out_next;
  logic test_reset_reg;
  logic [`ICT_PAIRS-1:0] paired_in;
  logic float_req;
  logic strobe_both;
  logic strobe_prev_reg;
  logic strobe_toggle;
  logic cpu_double_rate_clock_act;
  logic bosc_act;
  logic clock_act;
  logic internal_rst;

  ////////////////////////////////////////////////////////////////////////////
  // activity on either watched clock
  ict_activity_detect u_cpu_double_rate_clock_watch (
    .i_clk(i_clk),
    .i_rst(internal_rst),
    .i_level(i_cpu_double_rate_clock),
    .o_change(cpu_double_rate_clock_act)
  );

  ict_activity_detect u_bosc_watch (
    .i_clk(i_clk),
    .i_rst(internal_rst),
    .i_level(i_bus_oscillator_input),
    .o_change(bosc_act)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode of requests
  assign float_req = ~i_power_ok_input & ~i_speaker_float_shared_pin; // R5
  assign strobe_both = ~i_io_read_n & ~i_io_write_n;
  assign strobe_toggle = strobe_both & ~strobe_prev_reg; // R6
  assign clock_act = cpu_double_rate_clock_act | bosc_act;
  assign internal_rst = i_rst | test_reset_reg; // R9

  // fixed pairing: output k follows input reversed index, a constant map
  genvar k;
  generate
    for (k = 0; k < `ICT_PAIRS; k = k + 1) begin : g_pair
      assign paired_in[k] = i_test_in[`ICT_PAIRS-1-k]; // R12
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // mode sequencing
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ict_pkg::ST_NORMAL: begin
        if (float_req) begin
          state_next = ict_pkg::ST_FLOATED; // R1
        end
      end
      ict_pkg::ST_FLOATED: begin
        if (strobe_toggle) begin
          state_next = ict_pkg::ST_TEST; // R6
        end else if (!float_req) begin
          state_next = ict_pkg::ST_NORMAL;
        end
      end
      ict_pkg::ST_TEST: begin
        state_next = ict_pkg::ST_TEST; // R8
      end
    endcase
  end

  // registered pad data; test mode uses paired inputs
  assign pad_out_next = (state_next == ict_pkg::ST_TEST) ? paired_in : i_func_out; // R2

  // test modes cleared by any reset, including the clock-activity reset
  always_ff @(posedge i_clk) begin
    if (internal_rst) begin
      state_reg <= ict_pkg::ST_NORMAL; // R3
      strobe_prev_reg <= `ICT_ZERO;
      pad_out_reg <= '0;
    end else begin
      state_reg <= state_next;
      strobe_prev_reg <= strobe_both;
      pad_out_reg <= pad_out_next;
    end
  end

  // one-cycle self reset when a clock moves during test mode
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      test_reset_reg <= `ICT_ZERO;
    end else begin
      test_reset_reg <= (state_reg == ict_pkg::ST_TEST) & clock_act & ~test_reset_reg; // R9
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pad drive; float wins while in the floated state, a float request in test mode is ignored
  assign o_floated = (state_reg == ict_pkg::ST_FLOATED); // R1
  assign o_test_mode = (state_reg == ict_pkg::ST_TEST);
  assign o_test_reset = test_reset_reg;
  assign o_pad_out = pad_out_reg;
  assign o_pad_oe = o_floated ? '0 : (o_test_mode ? '1 : i_func_oe); // R1 R2
  assign o_speaker_out = i_speaker_out;
  // shared pin never driven while power is low, so it reads as an input
  assign o_speaker_oe = i_power_ok_input & ~o_floated & ~o_test_mode; // R4
endmodule

// *** hw/ict_defs.svh ***
// constants for the board connectivity test control block
`ifndef ICT_DEFS_SVH
`define ICT_DEFS_SVH
`define ICT_PAIRS 8
`define ICT_PIN_IDX_W 3
`define ICT_ONE 1'b1
`define ICT_ZERO 1'b0
`endif

// *** hw/ict_pkg.sv ***
// types for the board connectivity test control block
package ict_pkg;
  typedef enum logic [1:0] {
    ST_NORMAL,
    ST_FLOATED,
    ST_TEST
  } ict_state_t;
endpackage

// *** hw/ict_activity_detect.sv ***
// change detector for a synchronous level input
`timescale 1ns/1ns
module ict_activity_detect (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // watched level
  input wire logic i_level,
  // one-cycle pulse on any change
  output logic o_change
);
  logic prev_reg;
  logic seen_reg;

  // seen_reg masks the first sample so a static level after reset is not a change
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      prev_reg <= `ICT_ZERO;
      seen_reg <= `ICT_ZERO;
    end else begin
      prev_reg <= i_level;
      seen_reg <= `ICT_ONE;
    end
  end

  assign o_change = seen_reg & (prev_reg != i_level);
endmodule

// *** testbench/ict_fixture.sv ***
// board tester model: power, shared pin, strobes and clocks
`timescale 1ns/1ns
module ict_fixture (
  input wire logic i_clk,
  output logic o_pok = 1'b1, o_pin = 1'b1, o_rd_n = 1'b1, o_wr_n = 1'b1,
  output logic o_c2 = 1'b0, o_bo = 1'b0
);
  // applied at the falling edge; a released pin is driven high by the model
  task automatic drv(input logic [5:0] v);
    @(negedge i_clk);
    {o_pok, o_pin, o_rd_n, o_wr_n, o_c2, o_bo} = v;
  endtask
endmodule

// *** testbench/ict_ctl_asserts.sv ***
// assertions for the connectivity test control block
`timescale 1ns/1ns
module ict_ctl_asserts (
  input wire logic i_clk, i_rst, i_power_ok_input, i_speaker_float_shared_pin,
  input wire logic i_io_read_n, i_io_write_n, i_cpu_double_rate_clock, i_bus_oscillator_input,
  input wire logic [7:0] i_test_in, o_pad_out, o_pad_oe,
  input wire logic o_test_mode, o_floated, o_test_reset
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // low only while both strobes are low
  wire strb = i_io_read_n | i_io_write_n;
  sequence clk_act;
    $changed(i_cpu_double_rate_clock) || $changed(i_bus_oscillator_input);
  endsequence
  sequence test_drop;
    o_test_reset ##1 !o_test_mode;
  endsequence
  chk_float_entry: assert property (!(o_test_mode | o_floated) && !i_power_ok_input
    && !i_speaker_float_shared_pin |=> o_floated) else $error("float missed");
  chk_float_pads: assert property (o_floated |-> o_pad_oe == 8'h00)
    else $error("pads driven while floated");
  chk_test_entry: assert property (o_floated && !strb && $past(strb) |=> o_test_mode)
    else $error("test entry missed");
  chk_test_hold: assert property (o_test_mode && !o_test_reset |=> o_test_mode)
    else $error("test mode lost");
  chk_test_pads: assert property (o_test_mode |-> o_pad_oe == 8'hFF)
    else $error("pads not driven in test");
  chk_pair_map: assert property (o_test_mode && $past(o_test_mode)
    |-> o_pad_out == {<<{$past(i_test_in)}}) else $error("pairing wrong");
  chk_clock_reset: assert property (o_test_mode && !o_test_reset ##0 clk_act
    |=> test_drop) else $error("clock activity ignored");
  chk_reset_clear: assert property (o_test_reset |=> !o_test_mode && !o_floated)
    else $error("modes survive reset");
endmodule
bind in_circuit_test_control ict_ctl_asserts chk_u (.*);

// *** testbench/tb.sv ***
// testbench for the connectivity test control block
`timescale 1ns/1ns
module tb;
  logic i_clk = 1'b0, i_rst = 1'b1, i_speaker_out = 1'b0;
  logic i_power_ok_input, i_speaker_float_shared_pin, i_io_read_n, i_io_write_n;
  logic i_cpu_double_rate_clock, i_bus_oscillator_input;
  logic [7:0] i_test_in = 8'h35, i_func_out = 8'hC3, i_func_oe = 8'h5A, o_pad_out, o_pad_oe;
  logic o_speaker_out, o_speaker_oe, o_test_mode, o_floated, o_test_reset;
  int errors = 0, check_count = 0;
  wire [17:0] st = {o_test_mode, o_floated, o_pad_oe, o_pad_out};
  ict_fixture fx (.i_clk(i_clk), .o_pok(i_power_ok_input), .o_pin(i_speaker_float_shared_pin),
    .o_rd_n(i_io_read_n), .o_wr_n(i_io_write_n), .o_c2(i_cpu_double_rate_clock),
    .o_bo(i_bus_oscillator_input));
  in_circuit_test_control dut_u (.*);
  // compare and count
  task automatic chk(input logic [17:0] a, e);
    check_count++;
    if (a !== e) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, a, e);
    end
  endtask
  task automatic finish_test();
    if (errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // normal pass-through with power good, so function inputs are exercised
  task automatic t_func();
    i_func_out = 8'h96;
    i_func_oe = 8'hA5;
    i_speaker_out = 1'b1;
    @(negedge i_clk);
    chk(st, {2'b00, 8'hA5, 8'h96});
    chk({16'h0, o_speaker_out, o_speaker_oe}, 18'h3);
    i_func_out = 8'hC3;
    i_func_oe = 8'h5A;
    i_speaker_out = 1'b0;
  endtask
  // float, release, then strobes outside float
  task automatic t_float();
    fx.drv(6'b001100);
    @(negedge i_clk);
    chk(st, {2'b01, 8'h00, 8'hC3});
    chk({17'h0, o_speaker_oe}, 18'h0);
    fx.drv(6'b111100);
    fx.drv(6'b110000);
    @(negedge i_clk);
    chk(st, {2'b00, 8'h5A, 8'hC3});
  endtask
  // full entry order, clock runs with power low first
  task automatic t_enter(input logic [7:0] e);
    fx.drv(6'b011110);
    fx.drv(6'b011100);
    fx.drv(6'b001100);
    fx.drv(6'b000000);
    fx.drv(6'b001100);
    fx.drv(6'b011100);
    fx.drv(6'b111100);
    @(negedge i_clk);
    chk(st, {2'b10, 8'hFF, e});
  endtask
  // pairing follows inputs, float refused, clock activity ends test
  task automatic t_test();
    i_test_in = 8'h0F;
    @(negedge i_clk);
    chk(st, {2'b10, 8'hFF, 8'hF0});
    fx.drv(6'b001100);
    @(negedge i_clk);
    chk(st, {2'b10, 8'hFF, 8'hF0});
    fx.drv(6'b111101);
    repeat (3) @(negedge i_clk);
    chk(st, {2'b00, 8'h5A, 8'hC3});
  endtask
  task automatic t_reset();
    i_rst = 1'b1;
    @(negedge i_clk);
    chk(st, {2'b00, 8'h5A, 8'h00});
    i_rst = 1'b0;
  endtask
  initial forever #2 i_clk = ~i_clk;
  // main sequence after a 16 cycle reset
  initial begin
    repeat (16) @(posedge i_clk);
    @(negedge i_clk) i_rst = 1'b0;
    t_func();
    t_float();
    t_enter(8'hAC);
    t_test();
    t_enter(8'hF0);
    t_reset();
    finish_test();
  end
  // about 46 cycles expected
  initial begin
    #4000;
    errors++;
    finish_test();
  end
endmodule
